// ===== hdl/ood_decoder.sv
// Purpose: decodes the parameter fields of one instruction
// Assumes: fetch supplies up to six bytes and the form's parameter kinds
// Notes: results registered one cycle after a request
//
// Function
// - middle field as extension 0 to 7
// - group 80 extension 0 needs middle 000; other middle values raise no formError
// - byte registers low 0-3, high 4-7
// - word registers accumulator through destination index
// - segment codes extra, code, stack, data
// - byte offset is byte after opcode
// - doubleword offset: four bytes, offset then segment
// - word offset is two bytes after opcode
// - immediate byte, signedness from immSigned
// - immediate word, two bytes taken as is; immSigned not used
// - opcode minus base gives byte register
// - opcode minus base gives word register
// - mode field selects register or displacement
// - mode 00 rm 110 is direct address
module ood_decoder
    import ood_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reqValid,
    input wire logic [47:0] instBytes,
    input wire logic hasModrm,
    input wire ood_mid_t midKind,
    input wire logic wordOp,
    input wire logic regInOpcode,
    input wire logic [7:0] opcodeBase,
    input wire ood_off_t offKind,
    input wire ood_imm_t immKind,
    input wire logic immSigned,
    output logic resValid,
    output logic [2:0] extSel,
    output logic [3:0] regSel,
    output logic [1:0] segSel,
    output logic segValid,
    output logic [2:0] rmSel,
    output logic rmIsReg,
    output logic directAddr,
    output logic [15:0] disp,
    output logic [15:0] offsetVal,
    output logic [15:0] segmentVal,
    output logic [15:0] immVal,
    output logic formError,
    output logic [3:0] instLen
);
    ////////////////////////////////////////////////////////////////
    // byte view and addressing split
    logic [7:0] b [0:5];
    ood_if fld ();

    for (genvar i = 0; i < 6; i++) begin : g_bytes
        assign b[i] = instBytes[8*i+7:8*i];
    end

    assign fld.hasModrm = hasModrm;

    ood_modrm_split u_split (
        .modrmByte(b[1]),
        .dispLo(b[2]),
        .dispHi(b[3]),
        .fld(fld)
    );

    ////////////////////////////////////////////////////////////////
    // combinational decode
    ood_state_t state_r, state_nxt;
    logic [2:0] extSel_nxt, rmSel_nxt;
    logic [3:0] regSel_nxt, instLen_nxt, immPos;
    logic [1:0] segSel_nxt;
    logic segValid_nxt, rmIsReg_nxt, directAddr_nxt, formError_nxt;
    logic [15:0] disp_nxt, offset_nxt, segment_nxt, imm_nxt;
    logic [7:0] regCode8;
    logic [7:0] ib, iwLo, iwHi;

    always_comb begin
        regCode8 = b[0] - opcodeBase;
        extSel_nxt = 3'h0;
        regSel_nxt = 4'h0;
        segSel_nxt = 2'h0;
        segValid_nxt = 1'b0;
        formError_nxt = 1'b0;
        // middle field: extension, general register or segment
        case (midKind)
            MID_EXT: begin
                extSel_nxt = fld.mid;
                // group 80 extension 0 must carry 000 in the middle field
                if (b[0] == OP_IMM_GROUP && fld.mid != EXT_ADD) begin
                    formError_nxt = 1'b0; // other extensions legal; 000 picks add
                end
            end
            MID_REG: begin
                // bit3 flags word; codes map per byte or word numbering
                regSel_nxt = {wordOp, fld.mid};
            end
            MID_SEG: begin
                segValid_nxt = (fld.mid[2] == 1'b0);
                segSel_nxt = fld.mid[1:0];
                formError_nxt = fld.mid[2];
            end
            default: begin
                formError_nxt = 1'b1;
            end
        endcase
        if (regInOpcode) begin
            regSel_nxt = {wordOp, regCode8[2:0]};
            formError_nxt = (regCode8 > 8'h07);
        end
        rmSel_nxt = fld.rm;
        rmIsReg_nxt = hasModrm && (fld.mode == MODE_REG);
        directAddr_nxt = fld.directAddr;
        disp_nxt = fld.disp;
        // offsets follow the opcode; immediates follow the addressing byte and displacement
        offset_nxt = 16'h0000;
        segment_nxt = 16'h0000;
        case (offKind)
            OFF_BYTE: offset_nxt = {{8{b[1][7]}}, b[1]};
            OFF_WORD: offset_nxt = {b[2], b[1]};
            OFF_DWORD: begin
                offset_nxt = {b[2], b[1]};
                segment_nxt = {b[4], b[3]};
            end
            default: offset_nxt = 16'h0000;
        endcase
        immPos = 4'h1 + (hasModrm ? 4'h1 : 4'h0) + fld.dispLen;
        ib = b[immPos[2:0]];
        iwLo = b[immPos[2:0]];
        iwHi = b[3'(immPos[2:0] + 3'h1)];
        case (immKind)
            IMM_BYTE: imm_nxt = immSigned ? {{8{ib[7]}}, ib} : {8'h00, ib};
            IMM_WORD: imm_nxt = {iwHi, iwLo};
            default: imm_nxt = 16'h0000;
        endcase
        // total length lets fetch advance
        instLen_nxt = immPos;
        case (offKind)
            OFF_BYTE: instLen_nxt = instLen_nxt + 4'h1;
            OFF_WORD: instLen_nxt = instLen_nxt + 4'h2;
            OFF_DWORD: instLen_nxt = instLen_nxt + LEN_W;
            default: instLen_nxt = instLen_nxt;
        endcase
        case (immKind)
            IMM_BYTE: instLen_nxt = instLen_nxt + 4'h1;
            IMM_WORD: instLen_nxt = instLen_nxt + 4'h2;
            default: instLen_nxt = instLen_nxt;
        endcase
        state_nxt = reqValid ? ST_DONE : ST_IDLE;
    end

    ////////////////////////////////////////////////////////////////
    // result registers; outputs except resValid held until the next request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            extSel <= 3'h0;
            regSel <= 4'h0;
            segSel <= 2'h0;
            segValid <= 1'b0;
            rmSel <= 3'h0;
            rmIsReg <= 1'b0;
            directAddr <= 1'b0;
            disp <= 16'h0000;
            offsetVal <= 16'h0000;
            segmentVal <= 16'h0000;
            immVal <= 16'h0000;
            formError <= 1'b0;
            instLen <= RESET_LEN;
        end else begin
            state_r <= state_nxt;
            if (reqValid) begin
                extSel <= extSel_nxt;
                regSel <= regSel_nxt;
                segSel <= segSel_nxt;
                segValid <= segValid_nxt;
                rmSel <= rmSel_nxt;
                rmIsReg <= rmIsReg_nxt;
                directAddr <= directAddr_nxt;
                disp <= disp_nxt;
                offsetVal <= offset_nxt;
                segmentVal <= segment_nxt;
                immVal <= imm_nxt;
                formError <= formError_nxt;
                instLen <= instLen_nxt;
            end
        end
    end

    assign resValid = (state_r == ST_DONE);
endmodule

// ===== hdl/ood_pkg.sv
// Purpose: shared constants and types for the operand field decoder
// Assumes: one instruction presented per request, bytes little-endian
// Notes: byte positions count from the opcode at index 0
package ood_pkg;
    // addressing byte fields
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 6;
    localparam int MID_MSB = 5;
    localparam int MID_LSB = 3;
    localparam int RM_MSB = 2;
    localparam int RM_LSB = 0;
    localparam logic [1:0] MODE_NO_DISP = 2'h0;
    localparam logic [1:0] MODE_DISP8 = 2'h1;
    localparam logic [1:0] MODE_DISP16 = 2'h2;
    localparam logic [1:0] MODE_REG = 2'h3;
    localparam logic [2:0] RM_DIRECT = 3'h6;
    // opcodes with documented meaning
    localparam logic [7:0] OP_IMM_GROUP = 8'h80;
    localparam logic [2:0] EXT_ADD = 3'h0;
    localparam logic [7:0] OP_MOVE_IMM_BYTE_BASE = 8'hB0;
    localparam logic [7:0] OP_MOVE_IMM_WORD_BASE = 8'hB8;
    localparam logic [7:0] OP_INC_WORD_BASE = 8'h40;
    localparam logic [3:0] LEN_W = 4'h4;
    localparam logic [3:0] RESET_LEN = 4'h1;

    // operand parameter kind, chosen by the fetch logic's form table
    typedef enum logic [2:0] {
        OFF_NONE = 3'h0,
        OFF_BYTE = 3'h1, // byte_offset_param
        OFF_WORD = 3'h2, // word_offset_param
        OFF_DWORD = 3'h3 // doubleword_offset_param
    } ood_off_t;

    typedef enum logic [1:0] {
        IMM_NONE = 2'h0,
        IMM_BYTE = 2'h1, // immediate_byte_param
        IMM_WORD = 2'h2 // immediate_word_param
    } ood_imm_t;

    // how the middle addressing field is read
    typedef enum logic [1:0] {
        MID_EXT = 2'h0,
        MID_REG = 2'h1,
        MID_SEG = 2'h2
    } ood_mid_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_DONE = 2'h1
    } ood_state_t;
endpackage

// ===== hdl/ood_if.sv
// Purpose: carries the addressing byte fields between decoder modules
// Assumes: purely combinational fields
// Notes: none
interface ood_if;
    logic [1:0] mode;
    logic [2:0] mid;
    logic [2:0] rm;
    logic hasModrm;
    logic directAddr;
    logic [3:0] dispLen;
    logic [15:0] disp;
    modport split (output mode, mid, rm, directAddr, dispLen, disp, input hasModrm);
    modport use_ (input mode, mid, rm, directAddr, dispLen, disp, output hasModrm);
endinterface

// ===== hdl/ood_modrm_split.sv
// Purpose: splits the addressing byte and its displacement
// Assumes: bytes 1..3 are the addressing byte and following bytes
// Notes: combinational only
module ood_modrm_split
    import ood_pkg::*;
(
    input wire logic [7:0] modrmByte,
    input wire logic [7:0] dispLo,
    input wire logic [7:0] dispHi,
    ood_if.split fld
);
    ////////////////////////////////////////////////////////////////
    // field extraction and displacement size
    always_comb begin
        fld.mode = modrmByte[MODE_MSB:MODE_LSB];
        fld.mid = modrmByte[MID_MSB:MID_LSB];
        fld.rm = modrmByte[RM_MSB:RM_LSB];
        fld.directAddr = 1'b0;
        fld.dispLen = 4'h0;
        fld.disp = 16'h0000;
        if (fld.hasModrm) begin
            case (fld.mode)
                MODE_NO_DISP: begin
                    if (fld.rm == RM_DIRECT) begin
                        fld.directAddr = 1'b1;
                        fld.dispLen = 4'h2;
                        fld.disp = {dispHi, dispLo};
                    end
                end
                MODE_DISP8: begin
                    fld.dispLen = 4'h1;
                    fld.disp = {{8{dispLo[7]}}, dispLo};
                end
                MODE_DISP16: begin
                    fld.dispLen = 4'h2;
                    fld.disp = {dispHi, dispLo};
                end
                default: begin
                    fld.dispLen = 4'h0; // register operand
                end
            endcase
        end
    end
endmodule

// ===== tb/ood_fetch_model.sv
// Purpose: fetch-side model handing one instruction per request
// Assumes: send is called only after reset is released
// Notes: bytes are scrambled once released so stale data cannot pass
module ood_fetch_model
    import ood_pkg::*;
(
    input wire logic clk,
    output logic reqValid,
    output logic [47:0] instBytes,
    output logic hasModrm,
    output ood_mid_t midKind,
    output logic wordOp,
    output logic regInOpcode,
    output logic [7:0] opcodeBase,
    output ood_off_t offKind,
    output ood_imm_t immKind,
    output logic immSigned
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////
    // idle values at time zero
    initial begin
        {reqValid, instBytes, hasModrm, wordOp, regInOpcode, opcodeBase, immSigned} = '0;
        midKind = MID_EXT;
        offKind = OFF_NONE;
        immKind = IMM_NONE;
    end
    // one request, taken at the edge after it is raised
    task automatic send(input logic [47:0] b, input logic hm, input ood_mid_t mk,
        input logic w, input logic rio, input ood_off_t ok, input ood_imm_t ik, input logic sg);
        @(posedge clk) #1;
        {instBytes, hasModrm, wordOp, regInOpcode, immSigned} = {b, hm, w, rio, sg};
        {midKind, offKind, immKind} = {mk, ok, ik};
        opcodeBase = {b[7:3], 3'h0}; // base is the opcode with register bits cleared
        reqValid = 1'h1;
        @(posedge clk) #1;
        reqValid = 1'h0;
        instBytes = ~instBytes;
    endtask
endmodule

// ===== tb/ood_decoder_chk.sv
// Purpose: port-level checks of the operand field decoder
// Assumes: results show one cycle after a taken request
// Notes: none
module ood_decoder_chk
    import ood_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reqValid,
    input wire logic [47:0] instBytes,
    input wire logic hasModrm,
    input wire ood_mid_t midKind,
    input wire logic wordOp,
    input wire logic regInOpcode,
    input wire logic [7:0] opcodeBase,
    input wire ood_off_t offKind,
    input wire logic [2:0] extSel,
    input wire logic [3:0] regSel,
    input wire logic [1:0] segSel,
    input wire logic formError,
    input wire logic rmIsReg,
    input wire logic directAddr,
    input wire logic [15:0] offsetVal,
    input wire logic [15:0] segmentVal
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    // addressing byte fields of the request
    logic [7:0] md;
    assign md = instBytes[15:8];
    logic modrmReq;
    assign modrmReq = reqValid && hasModrm;
    AST_EXT_FIELD: assert property (modrmReq && midKind == MID_EXT
        |=> extSel == $past(md[5:3])) else $error("extension field wrong");
    AST_REG_FIELD: assert property (modrmReq && midKind == MID_REG && !regInOpcode
        |=> regSel == {$past(wordOp), $past(md[5:3])}) else $error("register field wrong");
    AST_SEG_FIELD: assert property (modrmReq && midKind == MID_SEG
        |=> segSel == $past(md[4:3]) && formError == $past(md[5])) else $error("segment wrong");
    AST_OPC_REG: assert property (reqValid && regInOpcode
        |=> regSel[2:0] == 3'($past(instBytes[7:0]) - $past(opcodeBase)))
        else $error("opcode register wrong");
    AST_OFF_BYTE: assert property (reqValid && offKind == OFF_BYTE
        |=> offsetVal == {{8{$past(instBytes[15])}}, $past(instBytes[15:8])})
        else $error("byte offset wrong");
    AST_OFF_WORD: assert property (reqValid && offKind == OFF_WORD
        |=> offsetVal == $past(instBytes[23:8])) else $error("word offset wrong");
    AST_OFF_DWORD: assert property (reqValid && offKind == OFF_DWORD
        |=> segmentVal == $past(instBytes[39:24])) else $error("segment value wrong");
    AST_MODE_REG: assert property (modrmReq
        |=> rmIsReg == ($past(md[7:6]) == MODE_REG)) else $error("register mode wrong");
    AST_DIRECT: assert property (modrmReq
        |=> directAddr == ($past(md[7:6]) == MODE_NO_DISP && $past(md[2:0]) == RM_DIRECT))
        else $error("direct address wrong");
endmodule
bind ood_decoder ood_decoder_chk i_ood_decoder_chk (.*);

// ===== tb/opcode_operand_field_decoder_bench.sv
// Purpose: self-checking bench of the operand field decoder
// Assumes: fetch model drives requests; results one cycle later
// Notes: offsets never combined with an addressing byte
module opcode_operand_field_decoder_bench
    import ood_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, reqValid, hasModrm, wordOp, regInOpcode, immSigned, resValid, segValid;
    logic rmIsReg, directAddr, formError;
    logic [47:0] instBytes;
    logic [7:0] opcodeBase;
    logic [2:0] extSel, rmSel;
    logic [3:0] regSel, instLen;
    logic [1:0] segSel;
    logic [15:0] disp, offsetVal, segmentVal, immVal;
    ood_mid_t midKind;
    ood_off_t offKind;
    ood_imm_t immKind;
    int fails = 0;
    int testsRun = 0;
    int cycles = 0;
    ood_decoder i_ood_decoder (.*);
    ood_fetch_model i_ood_fetch_model (.*);
    ////////////////////////////////////////////////////////////
    // clock and hang guard
    initial clk = 1'h0;
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        testsRun++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    // every extension code, with signed and unsigned immediate byte
    task automatic t_ext;
        for (int a = 0; a < 8; a++) begin
            i_ood_fetch_model.send({24'h0, 8'h85, 2'h3, a[2:0], 3'h3, 8'h80}, 1'h1, MID_EXT,
                1'h0, 1'h0, OFF_NONE, IMM_BYTE, a[0]);
            chk("valid", resValid, 16'h1);
            chk("ext", extSel, a[2:0]);
            chk("rm", rmSel, 16'h3);
            chk("imm", immVal, a[0] ? 16'hFF85 : 16'h0085);
            chk("len", instLen, 16'h3);
        end
        $display("done ext");
    endtask
    // byte, word and segment register codes in the middle field
    task automatic t_reg;
        for (int k = 0; k < 16; k++) begin
            // addressing byte sits after the opcode, never in byte 0
            i_ood_fetch_model.send({32'h0, 2'h3, k[2:0], 3'h0, 8'h8A}, 1'h1, MID_REG, k[3],
                1'h0, OFF_NONE, IMM_NONE, 1'h0);
            chk("reg", regSel, k[3:0]);
            i_ood_fetch_model.send({32'h0, 2'h3, k[2:0], 3'h0, 8'h8E}, 1'h1, MID_SEG, 1'h0,
                1'h0, OFF_NONE, IMM_NONE, 1'h0);
            chk("seg", segSel, k[1:0]);
            chk("segvalid", segValid, !k[2]);
            chk("segerr", formError, k[2]);
        end
        $display("done reg");
    endtask
    // register coded in opcode, byte and word immediate moves
    task automatic t_opc;
        for (int k = 0; k < 16; k++) begin
            i_ood_fetch_model.send({24'h0, 8'h12, 8'h34, 8'hB0 + k[7:0]}, 1'h0, MID_REG, k[3],
                1'h1, OFF_NONE, k[3] ? IMM_WORD : IMM_BYTE, 1'h0);
            chk("opreg", regSel, k[3:0]);
            chk("operr", formError, 16'h0);
            chk("opimm", immVal, k[3] ? 16'h1234 : 16'h0034);
            chk("oplen", instLen, k[3] ? 16'h3 : 16'h2);
        end
        $display("done opc");
    endtask
    // byte, word and doubleword offsets
    task automatic t_off;
        for (int k = 1; k < 4; k++) begin
            i_ood_fetch_model.send({16'h0, 24'h123456, 8'h98, 8'hE8}, 1'h0, MID_EXT, 1'h0,
                1'h0, ood_off_t'(k), IMM_NONE, 1'h0);
            chk("off", offsetVal, k == 1 ? 16'hFF98 : 16'h5698);
            chk("offlen", instLen, k == 3 ? 16'h5 : 16'(k + 1));
        end
        chk("offseg", segmentVal, 16'h1234);
        $display("done off");
    endtask
    // all four modes with rm 110, the direct case included
    task automatic t_mode;
        for (int i = 0; i < 4; i++) begin
            i_ood_fetch_model.send({16'h0, 16'h1280, i[1:0], 6'h06, 8'h8B}, 1'h1, MID_REG,
                1'h1, 1'h0, OFF_NONE, IMM_NONE, 1'h0);
            chk("direct", directAddr, i == 0);
            chk("isreg", rmIsReg, i == 3);
            if (i < 3) chk("disp", disp, i == 1 ? 16'hFF80 : 16'h1280);
            chk("mlen", instLen, i == 3 ? 16'h2 : (i == 1 ? 16'h3 : 16'h4));
        end
        $display("done mode");
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // reset, then every scenario in turn
    initial begin
        rst_n = 1'h0;
        repeat (5) @(posedge clk);
        #1 rst_n = 1'h1;
        chk("rstlen", instLen, 16'h1);
        chk("rstvalid", resValid, 16'h0);
        t_ext();
        t_reg();
        t_opc();
        t_off();
        t_mode();
        tally_and_finish();
    end
endmodule
